// ---- logic/cosc_pkg.sv ----
// Constants, offsets and field layout for the shutdown control block
// Overview of operation
// [RL1] Software request bit forces shutdown state
// [RL2] Manual restart: clear, then next rising event
// [RL3] Auto restart clears request, resumes on rise
// [RL4] Active fault resets drive latches, overrides outputs
// [RL5] Sources individually selected, active while low
// [RL6] Level faults hold shutdown unless deselected
// [RL7] Software clear ignored while fault active
// [RL8] Two 2-bit override fields, pairs AC/BD
// [RL9] Polarity applies only to inactive override
// [RL10] One bit picks manual or automatic restart
// [RL11] Disabled: count writes load buffers directly
// [RL12] Enabled: buffers wait for load request
// [RL13] Hardware clears load request after transfer
// [RL14] Top control bit enables the module
// [RL15] Clock select: div4, system, oscillator, reserved
// [RL16] Three-bit output mode field
// [RL17] Keep oscillator running when selected, enabled
// [RL18] Pin input serves as event or fault
// [RL19] Operator programs overrides, request before enable
// [RL20] Operator starts by auto restart or clear
// [RL21] Overrides hold until first rise after clear
// [RL22] Eight independent shutdown source enable bits
// [RL23] Override encoding fixed: low/high/tristate/inactive
package cosc_pkg;
  localparam int DW = 8;
  localparam int NCNT = 6;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_SDCTL = 8'h08;
  localparam logic [7:0] OFF_SDSEL = 8'h0C;
  localparam logic [7:0] OFF_CNT0 = 8'h10;
  localparam logic [7:0] OFF_STEP = 8'h04;
  // Control register 0 fields
  localparam int EN_BIT = 7;
  localparam int LD_BIT = 6;
  localparam int CS_LO = 3;
  localparam int MD_LO = 0;
  localparam logic [7:0] CTRL0_MASK = 8'hDF;
  localparam logic [7:0] CTRL1_MASK = 8'h0F;
  // Shutdown control fields
  localparam int REQ_BIT = 7;
  localparam int ARS_BIT = 6;
  localparam int AC_LO = 4;
  localparam int BD_LO = 2;
  localparam logic [7:0] SDCTL_MASK = 8'hFC;
  localparam logic [7:0] RST_VAL = 8'h00;
  // Override encodings
  localparam logic [1:0] OVR_LOW = 2'h0;
  localparam logic [1:0] OVR_HIGH = 2'h1;
  localparam logic [1:0] OVR_TRI = 2'h2;
  localparam logic [1:0] OVR_INACT = 2'h3;
  // Clock select encodings
  localparam logic [1:0] CS_DIV4 = 2'h0;
  localparam logic [1:0] CS_SYS = 2'h1;
  localparam logic [1:0] CS_OSC = 2'h2;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  // Output modes
  typedef enum logic [2:0] {
    COSC_STEER = 3'h0, COSC_SYNC_STEER = 3'h1, COSC_FWD_FB = 3'h2,
    COSC_REV_FB = 3'h3, COSC_HALF_BR = 3'h4, COSC_PUSH_PULL = 3'h5
  } cosc_mode_t;
  localparam logic [2:0] MODE_LAST = 3'h5;
endpackage : cosc_pkg

// ---- logic/cosc_top.sv ----
// Auto-shutdown, override and buffer-load control with APB registers
`timescale 1ns/1ps
module cosc_top (
  // Clock, reset, freeze
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Events and faults
  input wire logic rise_event_in,
  input wire logic fall_event_in,
  input wire logic pin_in,
  input wire logic [6:0] fault_n_in,
  input wire logic osc_tick_in,
  // Output stage
  input wire logic [3:0] normal_level_in,
  input wire logic [3:0] inactive_level_in,
  output logic [3:0] out_level_out,
  output logic [3:0] out_en_out,
  output logic drive_reset_out,
  output logic shutdown_out,
  // Configuration towards the datapath
  output logic enable_out,
  output logic [2:0] mode_out,
  output logic gen_tick_out,
  output logic osc_keep_out,
  output logic pin_event_out,
  output logic [cosc_pkg::NCNT*cosc_pkg::DW-1:0] count_buf_out
);
  import cosc_pkg::*;

  logic [1:0] rst_q;
  logic rst_n;
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] sdctl_q;
  logic [7:0] sdsel_q;
  logic [NCNT-1:0][DW-1:0] cnt_q;
  logic [NCNT-1:0][DW-1:0] buf_q;
  logic hold_q;
  logic [1:0] div_q;
  logic [7:0] src_n;
  logic fault;
  logic wr;
  logic rd_setup;
  logic copy;
  logic [7:0] wb;
  logic [7:0] rdata_d;
  logic hit;

  // Count register index from byte address, NCNT means none
  function automatic logic [2:0] cnt_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFF_CNT0;
    if (a >= OFF_CNT0 && d[1:0] == 2'h0 && d[7:2] < 6'(NCNT))
      return d[4:2];
    return 3'(NCNT);
  endfunction : cnt_idx

  // Reset released through two flops
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // Bus decode; slave answers in the first access cycle
  assign wr = psel_in & penable_in & pwrite_in & clk_en_in;
  assign rd_setup = psel_in & ~penable_in & ~pwrite_in & clk_en_in;
  assign wb = pwdata_in[7:0];
  assign pready_out = 1'b1;
  assign hit = paddr_in[31:8] == 24'h0 &&
    (paddr_in[7:0] == OFF_CTRL0 || paddr_in[7:0] == OFF_CTRL1 ||
     paddr_in[7:0] == OFF_SDCTL || paddr_in[7:0] == OFF_SDSEL ||
     cnt_idx(paddr_in[7:0]) != 3'(NCNT));
  assign pslverr_out = psel_in & penable_in & ~hit;

  // Fault sources: bit 0 is the selected pin, all active low
  assign src_n = {fault_n_in, pin_in};
  assign fault = |(~src_n & sdsel_q); // [RL5] [RL22] [RL18]
  assign pin_event_out = pin_in; // [RL18]

  // Read mux, captured in the setup cycle
  always_comb
  begin
    rdata_d = RST_VAL;
    if (paddr_in[31:8] == 24'h0)
    begin
      case (paddr_in[7:0])
        OFF_CTRL0: rdata_d = ctrl0_q;
        OFF_CTRL1: rdata_d = ctrl1_q;
        OFF_SDCTL: rdata_d = sdctl_q;
        OFF_SDSEL: rdata_d = sdsel_q;
        default:
        begin
          if (cnt_idx(paddr_in[7:0]) != 3'(NCNT))
            rdata_d = cnt_q[cnt_idx(paddr_in[7:0])];
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      prdata_out <= 32'h0;
    else if (rd_setup)
      prdata_out <= {24'h0, rdata_d};
  end

  // Control registers 0 and 1; load flag cleared by hardware
  assign copy = ctrl0_q[LD_BIT] &
    (~ctrl0_q[EN_BIT] | rise_event_in | fall_event_in);
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl0_q <= RST_VAL;
      ctrl1_q <= RST_VAL;
    end
    else if (clk_en_in)
    begin
      if (wr && paddr_in[7:0] == OFF_CTRL0 && hit)
        ctrl0_q <= wb & CTRL0_MASK; // [RL14] [RL15] [RL16]
      else if (copy)
        ctrl0_q[LD_BIT] <= 1'b0; // [RL13]
      if (wr && paddr_in[7:0] == OFF_CTRL1 && hit)
        ctrl1_q <= wb & CTRL1_MASK;
    end
  end
  assign enable_out = ctrl0_q[EN_BIT]; // [RL14]
  assign mode_out = ctrl0_q[MD_LO+:3]; // [RL16]

  // Source select register
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      sdsel_q <= RST_VAL;
    else if (clk_en_in && wr && paddr_in[7:0] == OFF_SDSEL && hit)
      sdsel_q <= wb; // [RL22]
  end

  // Shutdown control; a fault or set write beats any clear
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      sdctl_q <= RST_VAL;
    else if (clk_en_in)
    begin
      if (wr && paddr_in[7:0] == OFF_SDCTL && hit)
        sdctl_q <= wb & SDCTL_MASK; // [RL1] [RL8] [RL10]
      else if (sdctl_q[ARS_BIT] && !fault)
        sdctl_q[REQ_BIT] <= 1'b0; // [RL3]
      if (fault)
        sdctl_q[REQ_BIT] <= 1'b1; // [RL4] [RL6] [RL7]
    end
  end

  // Held shutdown state, left only on a rising event
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      hold_q <= 1'b0;
    else if (clk_en_in)
    begin
      if (sdctl_q[REQ_BIT] || fault)
        hold_q <= 1'b1; // [RL1] [RL6]
      else if (rise_event_in)
        hold_q <= 1'b0; // [RL2] [RL3] [RL21]
    end
  end

  // Fault acts combinationally so no clock edge is needed
  assign shutdown_out = hold_q | sdctl_q[REQ_BIT] | fault; // [RL4]
  assign drive_reset_out = shutdown_out; // [RL4]

  // Output levels; forced levels ignore polarity
  always_comb
  begin
    out_level_out = normal_level_in ^ ctrl1_q[3:0];
    out_en_out = 4'hF;
    if (shutdown_out)
    begin
      for (int i = 0; i < 4; i++)
      begin
        case (i[0] ? sdctl_q[BD_LO+:2] : sdctl_q[AC_LO+:2]) // [RL8]
          OVR_LOW: out_level_out[i] = 1'b0; // [RL9] [RL23]
          OVR_HIGH: out_level_out[i] = 1'b1; // [RL9] [RL23]
          OVR_TRI:
          begin
            out_level_out[i] = 1'b0;
            out_en_out[i] = 1'b0; // [RL23]
          end
          default:
            out_level_out[i] = inactive_level_in[i] ^ ctrl1_q[i]; // [RL9]
        endcase
      end
    end
  end

  // Count registers and their working buffers
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      buf_q <= '0;
    end
    else if (clk_en_in)
    begin
      for (int i = 0; i < NCNT; i++)
      begin
        if (wr && cnt_idx(paddr_in[7:0]) == 3'(i) && hit)
        begin
          cnt_q[i] <= wb;
          if (!ctrl0_q[EN_BIT])
            buf_q[i] <= wb; // [RL11]
        end
        else if (copy)
          buf_q[i] <= cnt_q[i]; // [RL12]
      end
    end
  end
  assign count_buf_out = buf_q;

  // Generator clock tick; a tick enable avoids muxing clocks
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 2'h0;
    else if (clk_en_in)
      div_q <= div_q + 2'h1;
  end
  always_comb
  begin
    case (ctrl0_q[CS_LO+:2])
      CS_DIV4: gen_tick_out = clk_en_in & (div_q == DIV4_LAST); // [RL15]
      CS_SYS: gen_tick_out = clk_en_in; // [RL15]
      CS_OSC: gen_tick_out = osc_tick_in; // [RL15] [RL17]
      default: gen_tick_out = 1'b0;
    endcase
  end
  // Sleep does not stop the oscillator while it clocks us and the module is enabled
  assign osc_keep_out = ctrl0_q[EN_BIT] &
    (ctrl0_q[CS_LO+:2] == CS_OSC); // [RL17]

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  a_sw_entry: assert property (wr && hit && paddr_in[7:0] == OFF_SDCTL &&
    wb[REQ_BIT] |=> shutdown_out ##1 hold_q) // [RL1]
    else $error("software request did not shut down");
  a_fault_now: assert property (fault |-> drive_reset_out &&
    shutdown_out) // [RL4]
    else $error("fault did not override at once");
  a_fault_keeps: assert property (fault && clk_en_in |=>
    sdctl_q[REQ_BIT] && hold_q) // [RL7]
    else $error("request cleared under active fault");
  a_auto_clear: assert property (clk_en_in && sdctl_q[ARS_BIT] &&
    sdctl_q[REQ_BIT] && !fault && !wr |=> !sdctl_q[REQ_BIT]) // [RL3]
    else $error("auto restart did not clear request");
  a_manual_keep: assert property (clk_en_in && !sdctl_q[ARS_BIT] &&
    sdctl_q[REQ_BIT] && !wr |=> sdctl_q[REQ_BIT]) // [RL2]
    else $error("request cleared without software");
  a_resume_rise: assert property (clk_en_in && hold_q && !fault &&
    !sdctl_q[REQ_BIT] && rise_event_in |=> !hold_q) // [RL21]
    else $error("no resume on rising event");
  a_no_early: assert property (clk_en_in && hold_q &&
    !rise_event_in |=> hold_q) // [RL21]
    else $error("left shutdown without rising event");
  a_load_done: assert property (clk_en_in && ctrl0_q[LD_BIT] && // [RL13]
    ctrl0_q[EN_BIT] && rise_event_in && !wr |=> !ctrl0_q[LD_BIT])
    else $error("load flag not cleared");
  a_buf_wait: assert property (clk_en_in && ctrl0_q[EN_BIT] &&
    !ctrl0_q[LD_BIT] |=> $stable(buf_q)) // [RL12]
    else $error("buffer changed without load");
  a_div4_tick: assert property (ctrl0_q[CS_LO+:2] == CS_DIV4 &&
    gen_tick_out |=> (!gen_tick_out ||
    ctrl0_q[CS_LO+:2] != CS_DIV4)[*3]) // [RL15]
    else $error("divide by four tick too frequent");

  // Forced low ignores polarity and keeps the driver on
  a_ovr_low: assert property (shutdown_out &&
    sdctl_q[AC_LO+:2] == OVR_LOW |->
    !out_level_out[0] && !out_level_out[2] && out_en_out[0]) // [RL9]
    else $error("forced low override not driven");

  // Forced high ignores polarity as well
  a_ovr_high: assert property (shutdown_out &&
    sdctl_q[BD_LO+:2] == OVR_HIGH |->
    out_level_out[1] && out_level_out[3] && out_en_out[1]) // [RL9]
    else $error("forced high override not driven");

  // Tristate choice releases both outputs of the pair
  a_ovr_tri: assert property (shutdown_out &&
    sdctl_q[BD_LO+:2] == OVR_TRI |->
    !out_en_out[1] && !out_en_out[3]) // [RL8]
    else $error("tristate override still driving");

  // Inactive choice follows the inactive level and polarity
  a_ovr_inact: assert property (shutdown_out &&
    sdctl_q[AC_LO+:2] == OVR_INACT |-> out_en_out[0] &&
    out_level_out[0] == (inactive_level_in[0] ^ ctrl1_q[0])) // [RL9]
    else $error("inactive override level wrong");

  // Outside shutdown the pins show the normal drive
  a_normal_out: assert property (!shutdown_out |->
    out_en_out == 4'hF &&
    out_level_out == (normal_level_in ^ ctrl1_q[3:0])) // [RL2]
    else $error("normal drive not passed through");

  // Disabled generator takes count writes straight into buffers
  a_direct_load: assert property (clk_en_in && wr && hit &&
    !ctrl0_q[EN_BIT] && cnt_idx(paddr_in[7:0]) == 3'h0 |=>
    buf_q[0] == $past(wb)) // [RL11]
    else $error("count write not loaded while disabled");

  // All buffers move together on a load with no count write
  a_load_copy: assert property (clk_en_in && copy && !wr |=>
    buf_q == $past(cnt_q)) // [RL12]
    else $error("buffers not copied together");

  // No selected source means no fault at all
  a_desel_quiet: assert property (sdsel_q == RST_VAL |->
    !fault) // [RL22]
    else $error("fault seen with no source selected");

  // Oscillator kept alive and used while selected with the module enabled
  a_osc_keep: assert property (ctrl0_q[EN_BIT] &&
    ctrl0_q[CS_LO+:2] == CS_OSC |->
    osc_keep_out && gen_tick_out == osc_tick_in) // [RL17]
    else $error("oscillator not kept as generator clock");

  // System clock choice ticks on every enabled cycle
  a_sys_tick: assert property (ctrl0_q[CS_LO+:2] == CS_SYS |->
    gen_tick_out == clk_en_in) // [RL15]
    else $error("system clock tick missing");

  // Enable bit follows the written value
  a_en_write: assert property (clk_en_in && wr && hit &&
    paddr_in[7:0] == OFF_CTRL0 |=>
    enable_out == $past(wb[EN_BIT])) // [RL14]
    else $error("enable bit not written");

  // Clock enable low must freeze the shutdown, control 0 and buffer registers
  a_freeze: assert property (!clk_en_in |=>
    $stable(sdctl_q) && $stable(ctrl0_q) && $stable(buf_q))
    else $error("state changed while frozen");

  c_fault_shut: cover property (fault ##1 !fault ##[1:20] !hold_q);
  c_auto_restart: cover property (sdctl_q[ARS_BIT] && sdctl_q[REQ_BIT]
    ##1 !sdctl_q[REQ_BIT] ##[1:20] !hold_q);
  c_load_copy: cover property (ctrl0_q[EN_BIT] && ctrl0_q[LD_BIT]
    ##[1:20] !ctrl0_q[LD_BIT]);
  // Tristate override reached at the pins
  c_tristate: cover property (shutdown_out && !out_en_out[1]);
  // Count write while disabled, the direct-load path
  c_direct_load: cover property (wr && !ctrl0_q[EN_BIT] &&
    cnt_idx(paddr_in[7:0]) != 3'(NCNT));
endmodule : cosc_top

// ---- verification/cosc_fault_model.sv ----
// Behavioural fault comparators feeding the shutdown inputs
`timescale 1ns/1ps
module cosc_fault_model (
  // Trip commands from the bench
  input wire logic [7:0] trip_in,
  // Low-active fault levels
  output logic pin_out,
  output logic [6:0] fault_n_out
);
  // A tripped comparator holds its line low for as long as it trips
  assign pin_out = ~trip_in[0];
  assign fault_n_out = ~trip_in[7:1];
endmodule : cosc_fault_model

// ---- verification/cosc_top_tb.sv ----
// Self-checking bench for the shutdown control block
`timescale 1ns/1ps
module cosc_top_tb;
  import cosc_pkg::*;
  logic clk, rst_n, psel, pen, pwr, rise, fall, pready, perr, serr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] trip;
  logic [6:0] flt_n;
  logic [3:0] lvl, en;
  logic pin, drv_rst, sd, gen_en, keep, pin_ev, cken, tick;
  logic [2:0] mode;
  logic [47:0] cbuf;
  int err_total, n_checks;

  cosc_top i_cosc_top (.clock_in(clk), .resetn_in(rst_n), .clk_en_in(cken),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .rise_event_in(rise), .fall_event_in(fall),
    .pin_in(pin), .fault_n_in(flt_n), .osc_tick_in(1'h0),
    .normal_level_in(4'hA), .inactive_level_in(4'h0),
    .out_level_out(lvl), .out_en_out(en), .drive_reset_out(drv_rst),
    .shutdown_out(sd), .enable_out(gen_en), .mode_out(mode),
    .gen_tick_out(tick), .osc_keep_out(keep), .pin_event_out(pin_ev),
    .count_buf_out(cbuf));

  cosc_fault_model i_cosc_fault_model (.trip_in(trip), .pin_out(pin),
    .fault_n_out(flt_n));

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= {24'h0, a};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    serr = perr;
    psel <= 1'h0;
    pen <= 1'h0;
    #1;
  endtask : apb

  // One-cycle rising or falling event
  task automatic pulse(input logic r);
    @(posedge clk);
    if (r)
      rise <= 1'h1;
    else
      fall <= 1'h1;
    @(posedge clk);
    rise <= 1'h0;
    fall <= 1'h0;
    #1;
  endtask : pulse

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // Watchdog: whole sequence needs well under 2000 cycles
  initial
  begin
    #100000;
    err_total++;
    conclude();
  end

  initial
  begin
    {psel, pen, pwr, rise, fall, rst_n} = '0;
    paddr = '0;
    pwdata = '0;
    trip = '0;
    cken = 1'h1;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    apb(1'h0, OFF_CTRL0, 8'h00);
    chk("ctrl0 reset", rd, 32'h0);
    apb(1'h1, OFF_CTRL1, 8'hFF);
    apb(1'h0, OFF_CTRL1, 8'h00);
    chk("ctrl1 mask", rd, 32'(CTRL1_MASK));
    apb(1'h1, OFF_CTRL1, 8'h00);
    apb(1'h0, 8'h40, 8'h00);
    chk("unmapped err", 32'(serr), 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'h1, OFF_CNT0, 8'h3C);
    chk("buf0 direct", 32'(cbuf[7:0]), 32'h3C);
    done("registers");
    // Start-up from the shutdown state
    apb(1'h1, OFF_SDCTL, 8'h90);
    apb(1'h1, OFF_CTRL0, 8'h85);
    chk("sd forced", 32'(sd), 32'h1);
    chk("ovr level", 32'(lvl), 32'h5);
    chk("ovr enable", 32'(en), 32'hF);
    apb(1'h1, OFF_SDCTL, 8'h10);
    chk("held", 32'(sd), 32'h1);
    pulse(1'h1);
    chk("resumed", 32'(sd), 32'h0);
    chk("normal", 32'(lvl), 32'hA);
    done("startup");
    apb(1'h1, OFF_CNT0 + OFF_STEP, 8'h5A);
    chk("buf1 held", 32'(cbuf[15:8]), 32'h0);
    apb(1'h1, OFF_CTRL0, 8'hC5);
    apb(1'h0, OFF_CTRL0, 8'h00);
    chk("load pending", rd, 32'hC5);
    pulse(1'h0);
    chk("buf1 loaded", 32'(cbuf[15:8]), 32'h5A);
    apb(1'h0, OFF_CTRL0, 8'h00);
    chk("load cleared", rd, 32'h85);
    done("load");
    // Fault on source 1 with inactive and tristate overrides
    apb(1'h1, OFF_SDSEL, 8'h02);
    apb(1'h1, OFF_CTRL1, 8'h01);
    @(posedge clk);
    trip <= 8'h02;
    #1;
    chk("fault sd", 32'(sd), 32'h1);
    chk("latch reset", 32'(drv_rst), 32'h1);
    apb(1'h1, OFF_SDCTL, 8'h38);
    apb(1'h0, OFF_SDCTL, 8'h00);
    chk("clear refused", rd, 32'hB8);
    chk("tristate", 32'(en), 32'h5);
    chk("inactive pol", 32'(lvl & 4'h5), 32'h1);
    pulse(1'h1);
    chk("level hold", 32'(sd), 32'h1);
    apb(1'h1, OFF_SDSEL, 8'h00);
    apb(1'h1, OFF_SDCTL, 8'h38);
    apb(1'h0, OFF_SDCTL, 8'h00);
    chk("deselected", rd, 32'h38);
    pulse(1'h1);
    chk("deselect run", 32'(sd), 32'h0);
    @(posedge clk);
    trip <= 8'h00;
    #1;
    done("fault");
    // Pin fault with automatic restart
    apb(1'h1, OFF_SDSEL, 8'h01);
    @(posedge clk);
    trip <= 8'h01;
    #1;
    chk("pin event", 32'(pin_ev), 32'h0);
    apb(1'h1, OFF_SDCTL, 8'h78);
    chk("pin sd", 32'(sd), 32'h1);
    @(posedge clk);
    trip <= 8'h00;
    repeat (2) @(posedge clk);
    apb(1'h0, OFF_SDCTL, 8'h00);
    chk("auto clear", rd, 32'h78);
    chk("auto held", 32'(sd), 32'h1);
    pulse(1'h1);
    chk("auto resume", 32'(sd), 32'h0);
    done("restart");
    // Every clock source and output mode
    for (int c = 0; c < 3; c++)
      for (int m = 0; m < 6; m++)
      begin
        apb(1'h1, OFF_CTRL0, {3'h4, c[1:0], m[2:0]});
        chk("mode", 32'(mode), 32'(m));
        chk("keep", 32'(keep), 32'(c == 2));
        chk("enable", 32'(gen_en), 32'h1);
        if (c != 0)
          chk("tick", 32'(tick), 32'(c == 1));
      end
    apb(1'h1, OFF_CTRL0, 8'h00);
    chk("disable", 32'(gen_en), 32'h0);
    done("modes");
    // Clock enable low ignores a register write
    @(posedge clk);
    cken <= 1'h0;
    apb(1'h1, OFF_CTRL1, 8'h0F);
    @(posedge clk);
    cken <= 1'h1;
    apb(1'h0, OFF_CTRL1, 8'h00);
    chk("frozen", rd, 32'h1);
    done("freeze");
    conclude();
  end
endmodule : cosc_top_tb
